// File: rtl/alarm_irq_pkg.sv
// Purpose: Constants and carrier types for the channel alarm status block
// Assumes: Channel n registers sit at n*0x10 plus the per-channel offset
// Notes: Global enables arrive as plain inputs
package alarm_irq_pkg;
  localparam int NUM_CH = 14;
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h05;
  localparam logic [7:0] OFS_CHANGE = 8'h06;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CHANGE_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int BIT_EQ = 7;
  localparam int BIT_DRV = 6;
  localparam int BIT_FIFO = 5;
  localparam int BIT_VIOL = 4;
  localparam int BIT_LOOP = 3;
  localparam int BIT_AIS = 2;
  localparam int BIT_LOS = 1;
  localparam int BIT_PRBS = 0;

  // Field order matches bits D7 down to D0
  typedef struct packed {
    logic equalizer_atten_flag;
    logic driver_fail_monitor;
    logic fifo_limit_alarm;
    logic violation_or_overflow;
    logic loop_code_detect;
    logic all_ones_alarm;
    logic receive_signal_loss;
    logic prbs_pattern_detect;
  } alarm_vec_t;
endpackage : alarm_irq_pkg

// File: rtl/channel_alarm_status_irq.sv
// Purpose: Per-channel live alarm status, change latches and interrupt gating
// Assumes: Detector inputs are synchronous to ref_clk; one-cycle cpu strobes
// Notes: Read data appears one cycle after the read strobe
// Operation
// - Enable bit D1 gates signal loss interrupt
// - Enable bit D0 gates prbs detect interrupt
// - Interrupt needs channel enable and global enable
// - Status follows detectors regardless of masking
// - D7 shows equalizer attenuation flag
// - D6 shows transmit driver failure
// - D5 shows jitter fifo limit
// - D4 violation, or counter overflow when selected
// - D4 violation covers code, bipolar, zeros
// - D3 shows loop code detect
// - D2 shows all-ones alarm
// - D1 shows receive signal loss
// - D0 shows prbs pattern detect
// - Fourteen status registers, cleared by reset
// - Changes latch, interrupt, clear on read
// - Enable bits D7 to D2 for others
`timescale 1ns/100ps
module channel_alarm_status_irq #(
  parameter int NUM_CH = alarm_irq_pkg::NUM_CH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Microprocessor port
  input wire logic cpu_cs,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_rdata_valid,
  // Global controls
  input wire logic global_irq_enable,
  input wire logic violation_count_mode,
  // Alarm detectors, one bit per channel
  input wire logic [NUM_CH-1:0] equalizer_atten_flag,
  input wire logic [NUM_CH-1:0] driver_fail_monitor,
  input wire logic [NUM_CH-1:0] fifo_limit_alarm,
  input wire logic [NUM_CH-1:0] line_code_violation,
  input wire logic [NUM_CH-1:0] violation_counter_overflow,
  input wire logic [NUM_CH-1:0] loop_code_detect,
  input wire logic [NUM_CH-1:0] all_ones_alarm,
  input wire logic [NUM_CH-1:0] receive_signal_loss,
  input wire logic [NUM_CH-1:0] prbs_pattern_detect,
  // Interrupt
  output logic irq
);

  function automatic logic [7:0] reg_addr(input int ch, input logic [7:0] ofs);
    logic [7:0] base;
    base = 8'(ch * alarm_irq_pkg::CH_STRIDE);
    return base + ofs;
  endfunction : reg_addr

  alarm_irq_pkg::alarm_vec_t status_r [NUM_CH];
  alarm_irq_pkg::alarm_vec_t live_nxt [NUM_CH];
  logic [7:0] enable_r [NUM_CH];
  logic [7:0] change_r [NUM_CH];
  logic [NUM_CH-1:0] ch_pending;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic irq_r;
  logic cpu_read;
  logic cpu_write;

  assign cpu_read = cpu_cs & cpu_rd;
  assign cpu_write = cpu_cs & cpu_wr;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic rd_change;
      assign rd_change = cpu_read && (cpu_addr == reg_addr(g, alarm_irq_pkg::OFS_CHANGE));

      always_comb begin
        live_nxt[g].equalizer_atten_flag = equalizer_atten_flag[g];
        live_nxt[g].driver_fail_monitor = driver_fail_monitor[g];
        live_nxt[g].fifo_limit_alarm = fifo_limit_alarm[g];
        live_nxt[g].violation_or_overflow = violation_count_mode ?
          violation_counter_overflow[g] : line_code_violation[g];
        live_nxt[g].loop_code_detect = loop_code_detect[g];
        live_nxt[g].all_ones_alarm = all_ones_alarm[g];
        live_nxt[g].receive_signal_loss = receive_signal_loss[g];
        live_nxt[g].prbs_pattern_detect = prbs_pattern_detect[g];
      end

      // Live status, never masked
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          status_r[g] <= alarm_irq_pkg::STATUS_RESET;
        end else begin
          status_r[g] <= live_nxt[g];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          enable_r[g] <= alarm_irq_pkg::ENABLE_RESET;
        end else if (cpu_write && (cpu_addr == reg_addr(g, alarm_irq_pkg::OFS_ENABLE))) begin
          enable_r[g] <= cpu_wdata;
        end
      end

      // New change wins over the read clear
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          change_r[g] <= alarm_irq_pkg::CHANGE_RESET;
        end else begin
          change_r[g] <= (rd_change ? alarm_irq_pkg::CHANGE_RESET : change_r[g])
                         | (status_r[g] ^ live_nxt[g]);
        end
      end

      assign ch_pending[g] = |(change_r[g] & enable_r[g]);

      a_change_latch: assert property (@(posedge ref_clk) disable iff (!rstn)
        (status_r[g] != live_nxt[g]) |=> ((change_r[g] & $past(status_r[g] ^ live_nxt[g]))
          == $past(status_r[g] ^ live_nxt[g])))
        else $error("alarm change not latched");
      a_read_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rd_change && (status_r[g] == live_nxt[g])) |=> (change_r[g] == 8'h00))
        else $error("change latch not cleared by read");
      a_status_follows: assert property (@(posedge ref_clk) disable iff (!rstn)
        ##1 (status_r[g] == $past(live_nxt[g])))
        else $error("status does not follow detector");
      a_viol_select: assert property (@(posedge ref_clk) disable iff (!rstn)
        violation_count_mode |=> (status_r[g][alarm_irq_pkg::BIT_VIOL]
          == $past(violation_counter_overflow[g])))
        else $error("overflow mode not selected on D4");
      a_viol_default: assert property (@(posedge ref_clk) disable iff (!rstn)
        !violation_count_mode |=> (status_r[g][alarm_irq_pkg::BIT_VIOL]
          == $past(line_code_violation[g])))
        else $error("violation not reported on D4");
      a_los_enable: assert property (@(posedge ref_clk) disable iff (!rstn)
        (global_irq_enable && change_r[g][alarm_irq_pkg::BIT_LOS]
          && enable_r[g][alarm_irq_pkg::BIT_LOS]) |=> irq)
        else $error("enabled signal loss change gave no interrupt");
      a_prbs_enable: assert property (@(posedge ref_clk) disable iff (!rstn)
        (global_irq_enable && change_r[g][alarm_irq_pkg::BIT_PRBS]
          && enable_r[g][alarm_irq_pkg::BIT_PRBS]) |=> irq)
        else $error("enabled prbs change gave no interrupt");
      a_eq_enable: assert property (@(posedge ref_clk) disable iff (!rstn)
        (global_irq_enable && change_r[g][alarm_irq_pkg::BIT_EQ]
          && enable_r[g][alarm_irq_pkg::BIT_EQ]) |=> irq)
        else $error("enabled equalizer change gave no interrupt");
      a_enable_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        (cpu_write && (cpu_addr == reg_addr(g, alarm_irq_pkg::OFS_ENABLE)))
          |=> (enable_r[g] == $past(cpu_wdata)))
        else $error("enable write not stored");
      c_set_wins: cover property (@(posedge ref_clk) disable iff (!rstn)
        rd_change && (status_r[g] != live_nxt[g]));
    end
  endgenerate

  // Read mux, unmapped space reads as zero
  always_comb begin
    rdata_nxt = alarm_irq_pkg::UNMAPPED_READ;
    for (int c = 0; c < NUM_CH; c++) begin
      if (cpu_addr == reg_addr(c, alarm_irq_pkg::OFS_ENABLE)) begin
        rdata_nxt = enable_r[c];
      end
      if (cpu_addr == reg_addr(c, alarm_irq_pkg::OFS_STATUS)) begin
        rdata_nxt = status_r[c];
      end
      if (cpu_addr == reg_addr(c, alarm_irq_pkg::OFS_CHANGE)) begin
        rdata_nxt = change_r[c];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata_r <= alarm_irq_pkg::RDATA_RESET;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= cpu_read;
      if (cpu_read) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // Registered interrupt, one cycle behind pending changes
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= global_irq_enable & (|ch_pending);
    end
  end

  assign cpu_rdata = rdata_r;
  assign cpu_rdata_valid = rvalid_r;
  assign irq = irq_r;

  a_global_mask: assert property (@(posedge ref_clk) disable iff (!rstn)
    !global_irq_enable |=> !irq)
    else $error("interrupt raised with global enable low");
  a_irq_cause: assert property (@(posedge ref_clk) disable iff (!rstn)
    ##1 (irq == ($past(global_irq_enable) && $past(|ch_pending))))
    else $error("interrupt does not match enabled changes");
  a_reset_clear: assert property (@(posedge ref_clk)
    !rstn |=> (status_r[0] == 8'h00 && change_r[0] == 8'h00 && !irq))
    else $error("reset did not clear status");
  a_read_status: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cpu_read && cpu_addr == 8'h05) |=> (cpu_rdata_valid && cpu_rdata == $past(status_r[0])))
    else $error("channel 0 status read wrong");
  a_masked_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(|ch_pending) |=> !irq)
    else $error("interrupt raised with nothing pending");

  c_irq_raised: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(irq));
  c_read_clear: cover property (@(posedge ref_clk) disable iff (!rstn)
    irq ##1 (cpu_read && cpu_addr == 8'h06) ##2 !irq);
  c_overflow_mode: cover property (@(posedge ref_clk) disable iff (!rstn)
    violation_count_mode && violation_counter_overflow[0]);
  c_last_channel: cover property (@(posedge ref_clk) disable iff (!rstn)
    cpu_read && cpu_addr == 8'hd5);

endmodule : channel_alarm_status_irq

// File: verification/tb_channel_alarm_status_irq.sv
// Purpose: Self-checking bench for channel_alarm_status_irq
// Assumes: Channel stride 0x10, read data valid one cycle after strobe
// Notes: Detector row 8 is the violation counter overflow input
`timescale 1ns/100ps
module tb_channel_alarm_status_irq;
  // Clock and reset
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  // Microprocessor port
  logic cpu_cs = 1'b0;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [7:0] cpu_addr = 8'h00;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata;
  logic cpu_rdata_valid;
  // Globals, detectors, interrupt
  logic global_irq_enable = 1'b0;
  logic violation_count_mode = 1'b0;
  logic [8:0][13:0] det = '0;
  logic irq;
  int err_count = 0;
  int total_checks = 0;

  channel_alarm_status_irq dut (.ref_clk(ref_clk), .rstn(rstn), .cpu_cs(cpu_cs),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .cpu_rdata_valid(cpu_rdata_valid),
    .global_irq_enable(global_irq_enable), .violation_count_mode(violation_count_mode),
    .equalizer_atten_flag(det[7]), .driver_fail_monitor(det[6]),
    .fifo_limit_alarm(det[5]), .line_code_violation(det[4]),
    .violation_counter_overflow(det[8]), .loop_code_detect(det[3]),
    .all_ones_alarm(det[2]), .receive_signal_loss(det[1]),
    .prbs_pattern_detect(det[0]), .irq(irq));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cpu_cs <= 1'b1;
    cpu_wr <= w;
    cpu_rd <= ~w;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge ref_clk);
    cpu_cs <= 1'b0;
    cpu_wr <= 1'b0;
    cpu_rd <= 1'b0;
  endtask : acc

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    #1;
    check({7'h00, cpu_rdata_valid}, 8'h01);
    check(cpu_rdata, exp);
  endtask : rd

  task automatic sdet(input int i, input int ch, input logic v);
    @(posedge ref_clk);
    det[i][ch] <= v;
  endtask : sdet

  task automatic irq_after(input int n, input logic exp);
    repeat (n) @(posedge ref_clk);
    #1;
    check({7'h00, irq}, {7'h00, exp});
  endtask : irq_after

  // Reset values, read-only status, unmapped space
  task automatic t_reset;
    rd(8'h04, 8'h00);
    acc(1'b1, 8'hd5, 8'hff);
    rd(8'hd5, 8'h00);
    rd(8'he5, 8'h00);
    irq_after(0, 1'b0);
  endtask : t_reset

  // Each alarm on the last channel, masked, plus D4 source select
  task automatic t_status;
    @(posedge ref_clk);
    global_irq_enable <= 1'b1;
    for (int b = 0; b < 8; b++) begin
      sdet(b, 13, 1'b1);
      rd(8'hd5, 8'h01 << b);
      irq_after(0, 1'b0);
      sdet(b, 13, 1'b0);
    end
    violation_count_mode <= 1'b1;
    sdet(4, 13, 1'b1);
    rd(8'hd5, 8'h00);
    sdet(8, 13, 1'b1);
    rd(8'hd5, 8'h10);
    sdet(8, 13, 1'b0);
    sdet(4, 13, 1'b0);
    violation_count_mode <= 1'b0;
    global_irq_enable <= 1'b0;
  endtask : t_status

  // Every enable bit on channel 0: global gate, latch, clear on read
  task automatic t_irq;
    for (int b = 0; b < 8; b++) begin
      acc(1'b1, 8'h04, 8'h01 << b);
      rd(8'h04, 8'h01 << b);
      sdet(b, 0, 1'b1);
      irq_after(2, 1'b0);
      @(posedge ref_clk);
      global_irq_enable <= 1'b1;
      irq_after(1, 1'b1);
      rd(8'h06, 8'h01 << b);
      irq_after(1, 1'b0);
      rd(8'h05, 8'h01 << b);
      sdet(b, 0, 1'b0);
      rd(8'h06, 8'h01 << b);
      @(posedge ref_clk);
      global_irq_enable <= 1'b0;
    end
  endtask : t_irq

  // A change in the clearing cycle survives the read
  task automatic t_set_wins;
    fork
      sdet(1, 0, 1'b1);
      rd(8'h06, 8'h00);
    join
    rd(8'h06, 8'h02);
    sdet(1, 0, 1'b0);
    rd(8'h06, 8'h02);
  endtask : t_set_wins

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_status();
    t_irq();
    t_set_wins();
    tally_and_finish();
  end
endmodule : tb_channel_alarm_status_irq
